/* ams_acq_mode_select.sv */
// Operation
// - Mode register read/write, reads current mode
// - Read-only bitmap of supported modes
// - Standard modes store only to on-board memory
// - Streaming uses whole memory as circular buffer
// - 1h: single trigger into memory
// - 2h: equal segment per trigger, memory
// - 4h: memory store only while gate matches
// - 8h: triggered segments plus slow stream
// - Statistics modes select statistics firmware module
// - Average modes select block-average firmware module
// - Boxcar modes need firmware version 29+
// - 10h: single trigger streamed to host
// - 20h: segment per trigger streamed to host
// - 40h: stream while gate is active
// - 80h: streamed segments plus slow stream
// - Monitor mode: streaming single plus slow stream
`timescale 1ns/1ps
module ams_acq_mode_select #(
	parameter int         P_MEM_ADDR_W  = 12,
	parameter int         P_SEG_W       = 16,
	parameter int         P_SLOW_DIV    = 16,
	parameter int         P_FIFO_DEPTH  = 32,
	parameter logic [7:0] P_FW_VERSION  = 8'h1d,
	parameter bit         P_HAS_STATS   = 1'b1,
	parameter bit         P_HAS_AVERAGE = 1'b1
) (
	input  wire logic                          i_core_clk,     // 10 MHz core clock
	input  wire logic                          i_rst_b,        // Async reset, low
	input  wire ams_pkg::ams_reg_req_t         i_reg,          // Register request
	output logic [31:0]                        o_reg_rdata,    // Read data
	output logic                               o_reg_ack,      // Access done
	output logic                               o_reg_err,      // Access refused
	input  wire logic                          i_run,          // Run level
	input  wire logic                          i_trig_pin,     // Trigger pin
	input  wire logic                          i_gate_pin,     // Gate pin
	input  wire logic                          i_gate_level,   // Gate active level
	input  wire logic [P_SEG_W-1:0]            i_seg_len,      // Samples per segment
	input  wire logic                          i_sample_valid, // Sample strobe
	input  wire logic [ams_pkg::SAMPLE_W-1:0]  i_sample_data,  // Sample value
	output logic                               o_mem_wr,       // Memory write
	output logic [P_MEM_ADDR_W-1:0]            o_mem_addr,     // Memory address
	output logic [ams_pkg::SAMPLE_W-1:0]       o_mem_data,     // Memory data
	output logic                               o_host_valid,   // Host word valid
	output ams_pkg::ams_word_t                 o_host_word,    // Host word
	input  wire logic                          i_host_ready,   // Host accepts
	output logic                               o_slow_valid,   // Slow sample strobe
	output logic [ams_pkg::SAMPLE_W-1:0]       o_slow_data,    // Slow sample
	output logic                               o_stream_mode,  // Streaming class
	output ams_pkg::ams_dsp_t                  o_dsp_select,   // Firmware module
	output logic                               o_busy,         // Armed or capturing
	output logic                               o_done,         // Run complete
	output logic                               o_overrun       // Stream sample lost
);
	import ams_pkg::*;

	if (P_MEM_ADDR_W < 2 || P_SEG_W < 1 || P_SLOW_DIV < 2 || P_FIFO_DEPTH < 2) begin : g_bad_cfg
		$error("ams_acq_mode_select parameter out of range");
	end

	localparam int SW = $clog2(P_SLOW_DIV);

	logic [31:0]             mode;
	logic [31:0]             next_mode;
	logic [31:0]             caps;
	logic                    wr_one_hot;
	logic                    wr_supported;
	logic                    cur_stream;
	logic                    cur_single;
	logic                    cur_gated;
	logic                    cur_slow;
	ams_dsp_t                cur_dsp;
	logic [31:0]             next_rdata;
	logic                    next_ack;
	logic                    next_err;
	ams_state_t              state;
	ams_state_t              next_state;
	logic [P_SEG_W-1:0]      seg_cnt;
	logic [P_SEG_W-1:0]      next_seg_cnt;
	logic [P_MEM_ADDR_W-1:0] wr_addr;
	logic [P_MEM_ADDR_W-1:0] next_wr_addr;
	logic [1:0]              trig_sync;
	logic [1:0]              gate_sync;
	logic                    trig_prev;
	logic                    run_prev;
	logic                    trig_rise;
	logic                    run_rise;
	logic                    gate_on;
	logic                    seg_last;
	logic                    last_addr;
	logic                    store;
	logic                    lost;
	logic [SW-1:0]           slow_cnt;
	logic [SW-1:0]           next_slow_cnt;
	logic                    slow_tick;
	logic                    slow_pend;
	logic                    next_slow_pend;
	logic [SAMPLE_W-1:0]     slow_hold;
	logic [SAMPLE_W-1:0]     next_slow_hold;
	logic                    fifo_push;
	ams_word_t               fifo_word;
	logic                    fifo_in_ready;
	logic                    fifo_out_valid;
	ams_word_t               fifo_out_word;
	logic                    fifo_pop;
	logic                    next_host_valid;
	ams_word_t               next_host_word;
	logic                    next_overrun;

	ams_mode_decode #(
		.P_FW_VERSION  (P_FW_VERSION),
		.P_HAS_STATS   (P_HAS_STATS),
		.P_HAS_AVERAGE (P_HAS_AVERAGE)
	) u_decode (
		.i_mode         (mode),
		.i_wr_value     (i_reg.wdata),
		.o_caps         (caps),
		.o_wr_one_hot   (wr_one_hot),
		.o_wr_supported (wr_supported),
		.o_stream       (cur_stream),
		.o_single       (cur_single),
		.o_gated        (cur_gated),
		.o_slow         (cur_slow),
		.o_dsp          (cur_dsp)
	);

	ams_fifo #(
		.W     ($bits(ams_word_t)),
		.DEPTH (P_FIFO_DEPTH)
	) u_fifo (
		.i_core_clk  (i_core_clk),
		.i_rst_b     (i_rst_b),
		.i_in_valid  (fifo_push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (fifo_word),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (fifo_pop),
		.o_out_data  (fifo_out_word)
	);

	// Register access; mode frozen outside idle so a run never switches class
	always_comb begin
		next_mode  = mode;
		next_rdata = 32'h0000_0000;
		next_ack   = i_reg.wr | i_reg.rd;
		next_err   = 1'h0;
		if (i_reg.rd) begin
			case (i_reg.addr)
				ADDR_MODE_SELECT: begin
					next_rdata = mode;
				end
				ADDR_SUPPORTED: begin
					next_rdata = caps;
				end
				default: begin
					next_err = 1'h1;
				end
			endcase
		end
		if (i_reg.wr) begin
			case (i_reg.addr)
				ADDR_MODE_SELECT: begin
					if (wr_one_hot && wr_supported && state == ST_IDLE) begin
						next_mode = i_reg.wdata;
					end else begin
						next_err = 1'h1;
					end
				end
				default: begin
					next_err = 1'h1;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mode        <= MODE_RESET;
			o_reg_rdata <= 32'h0000_0000;
			o_reg_ack   <= 1'h0;
			o_reg_err   <= 1'h0;
		end else begin
			mode        <= next_mode;
			o_reg_rdata <= next_rdata;
			o_reg_ack   <= next_ack;
			o_reg_err   <= next_err;
		end
	end

	// Pin synchronisers
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			trig_sync <= 2'h0;
			gate_sync <= 2'h0;
			trig_prev <= 1'h0;
			run_prev  <= 1'h0;
		end else begin
			trig_sync <= {trig_sync[0], i_trig_pin};
			gate_sync <= {gate_sync[0], i_gate_pin};
			trig_prev <= trig_sync[1];
			run_prev  <= i_run;
		end
	end

	assign trig_rise = trig_sync[1] & ~trig_prev;
	assign run_rise  = i_run & ~run_prev;
	assign gate_on   = (gate_sync[1] == i_gate_level);
	assign seg_last  = (seg_cnt == P_SEG_W'(i_seg_len - 1'h1));
	assign last_addr = (wr_addr == '1);

	// Acquisition sequence
	always_comb begin
		next_state   = state;
		next_seg_cnt = seg_cnt;
		next_wr_addr = wr_addr;
		store        = 1'h0;
		lost         = 1'h0;
		case (state)
			ST_IDLE: begin
				if (run_rise) begin
					next_state   = ST_ARMED;
					next_seg_cnt = '0;
					next_wr_addr = '0;
				end
			end
			ST_ARMED: begin
				if (!i_run) begin
					next_state = ST_DONE;
				end else if (cur_gated || trig_rise) begin
					next_state = ST_CAPTURE;
				end
			end
			ST_CAPTURE: begin
				if (!i_run) begin
					next_state = ST_DONE;
				end else if (i_sample_valid && (!cur_gated || gate_on)) begin
					if (cur_stream && !fifo_in_ready) begin
						lost = 1'h1;
					end else begin
						store        = 1'h1;
						next_wr_addr = wr_addr + 1'h1;
						next_seg_cnt = seg_cnt + 1'h1;
						if (!cur_stream && last_addr) begin
							next_state = ST_DONE;
						end else if (!cur_gated && seg_last) begin
							next_seg_cnt = '0;
							next_state   = cur_single ? ST_DONE : ST_ARMED;
						end
					end
				end
			end
			ST_DONE: begin
				if (!i_run) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Slow stream, one sample kept per divider period
	always_comb begin
		slow_tick      = 1'h0;
		next_slow_cnt  = slow_cnt;
		next_slow_hold = slow_hold;
		next_slow_pend = slow_pend;
		fifo_push      = 1'h0;
		fifo_word      = '{slow: 1'h0, data: i_sample_data};
		if (state == ST_IDLE) begin
			next_slow_cnt = '0;
		end else if (cur_slow && i_sample_valid) begin
			if (slow_cnt == SW'(P_SLOW_DIV - 1)) begin
				slow_tick     = 1'h1;
				next_slow_cnt = '0;
			end else begin
				next_slow_cnt = slow_cnt + 1'h1;
			end
		end
		if (store && cur_stream) begin
			fifo_push = 1'h1;
		end else if (slow_pend && fifo_in_ready) begin
			fifo_push      = 1'h1;
			fifo_word      = '{slow: 1'h1, data: slow_hold};
			next_slow_pend = 1'h0;
		end
		// A newer slow sample replaces one still waiting for a free slot
		if (slow_tick && cur_stream) begin
			next_slow_pend = 1'h1;
			next_slow_hold = i_sample_data;
		end
	end

	// Output stage keeps host signals on flops
	always_comb begin
		fifo_pop        = fifo_out_valid && (!o_host_valid || i_host_ready);
		next_host_valid = fifo_pop || (o_host_valid && !i_host_ready);
		next_host_word  = fifo_pop ? fifo_out_word : o_host_word;
		next_overrun    = run_rise ? 1'h0 : o_overrun;
		if (lost) begin
			next_overrun = 1'h1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state         <= ST_IDLE;
			seg_cnt       <= '0;
			wr_addr       <= '0;
			slow_cnt      <= '0;
			slow_pend     <= 1'h0;
			slow_hold     <= '0;
			o_mem_wr      <= 1'h0;
			o_mem_addr    <= '0;
			o_mem_data    <= '0;
			o_host_valid  <= 1'h0;
			o_host_word   <= '0;
			o_slow_valid  <= 1'h0;
			o_slow_data   <= '0;
			o_stream_mode <= 1'h0;
			o_dsp_select  <= DSP_NONE;
			o_busy        <= 1'h0;
			o_done        <= 1'h0;
			o_overrun     <= 1'h0;
		end else begin
			state         <= next_state;
			seg_cnt       <= next_seg_cnt;
			wr_addr       <= next_wr_addr;
			slow_cnt      <= next_slow_cnt;
			slow_pend     <= next_slow_pend;
			slow_hold     <= next_slow_hold;
			o_mem_wr      <= store;
			o_mem_addr    <= wr_addr;
			o_mem_data    <= i_sample_data;
			o_host_valid  <= next_host_valid;
			o_host_word   <= next_host_word;
			o_slow_valid  <= slow_tick && !cur_stream;
			o_slow_data   <= i_sample_data;
			o_stream_mode <= cur_stream;
			o_dsp_select  <= cur_dsp;
			o_busy        <= (next_state == ST_ARMED) || (next_state == ST_CAPTURE);
			o_done        <= (next_state == ST_DONE);
			o_overrun     <= next_overrun;
		end
	end

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);

	sequence s_mode_read;
		i_reg.rd && !i_reg.wr && i_reg.addr == ADDR_MODE_SELECT;
	endsequence

	sequence s_bad_write;
		i_reg.wr && i_reg.addr == ADDR_MODE_SELECT && !(wr_one_hot && wr_supported);
	endsequence

	sequence s_seg_end;
		state == ST_CAPTURE && store && !cur_gated && seg_last && (cur_stream || !last_addr);
	endsequence

	a_mode_readback: assert property (
		s_mode_read |=> o_reg_ack && !o_reg_err && o_reg_rdata == $past(mode))
		else $error("mode read returned wrong value");

	a_caps_readback: assert property (
		i_reg.rd && !i_reg.wr && i_reg.addr == ADDR_SUPPORTED |=> o_reg_rdata == caps && !o_reg_err)
		else $error("supported bitmap read wrong");

	a_bad_mode_kept: assert property (
		s_bad_write |=> o_reg_err && mode == $past(mode))
		else $error("invalid mode write not rejected");

	a_good_mode_taken: assert property (
		i_reg.wr && i_reg.addr == ADDR_MODE_SELECT && wr_one_hot && wr_supported
			&& state == ST_IDLE |=> mode == $past(i_reg.wdata) && !o_reg_err)
		else $error("valid mode write not taken");

	a_std_mem_only: assert property (
		!cur_stream |-> !fifo_push)
		else $error("standard mode pushed to host stream");

	a_stream_wraps: assert property (
		store && cur_stream && last_addr |=> wr_addr == '0 && o_mem_wr && o_mem_addr == '1)
		else $error("streaming buffer did not wrap");

	a_single_ends: assert property (
		s_seg_end and cur_single |=> state == ST_DONE && o_done)
		else $error("single acquisition did not finish");

	a_multi_rearm: assert property (
		s_seg_end and !cur_single |=> state == ST_ARMED && seg_cnt == '0)
		else $error("multi acquisition did not re-arm");

	a_gate_respected: assert property (
		o_mem_wr && cur_gated |-> $past(gate_sync[1]) == $past(i_gate_level))
		else $error("gated sample stored with gate inactive");

	a_boxcar_select: assert property (
		cur_dsp == DSP_BOXCAR |-> (caps & BOXCAR_MODES) != 32'h0000_0000
			##1 o_dsp_select == DSP_BOXCAR)
		else $error("boxcar selection wrong");

endmodule // ams_acq_mode_select

/* ams_acq_mode_select_bench.sv */
`timescale 1ns/1ps
module ams_acq_mode_select_bench;
	import ams_pkg::*;
	logic               clk = 1'b0;
	logic               rst_b = 1'b0;
	ams_reg_req_t       req = '0;
	logic               run = 1'b0;
	logic               trig = 1'b0;
	logic               gate = 1'b0;
	logic               glvl = 1'b1;
	logic               sv = 1'b0;
	logic [15:0]        sd = 16'h0000;
	logic [15:0]        seg_len = 16'h0002;
	logic               host_ready;
	logic [31:0]        rdata;
	logic               ack, err, mwr, hval, slow_v, strm, busy, done, ovr;
	logic [3:0]         maddr;
	logic [15:0]        mdata, slow_d;
	ams_word_t          hword;
	ams_dsp_t           dsp;
	logic [35:0]        rq[$], mq[$], hq[$], sq[$];
	int                 n_errors = 0;
	int                 check_count = 0;
	int                 cyc = 0;
	logic [31:0]        caps, cur;
	logic [31:0]        runs[9] = '{MODE_MEM_SINGLE, MODE_MEM_MULTI, MODE_STREAM_SINGLE,
		MODE_STREAM_MULTI, MODE_MEM_GATED, MODE_STREAM_GATED, MODE_MEM_DUAL_RATE,
		MODE_STREAM_DUAL_RATE, MODE_STREAM_SINGLE_WITH_MONITOR};

	ams_acq_mode_select #(.P_MEM_ADDR_W(4), .P_SLOW_DIV(2)) u_dut (
		.i_core_clk(clk), .i_rst_b(rst_b), .i_reg(req), .o_reg_rdata(rdata),
		.o_reg_ack(ack), .o_reg_err(err), .i_run(run), .i_trig_pin(trig),
		.i_gate_pin(gate), .i_gate_level(glvl), .i_seg_len(seg_len),
		.i_sample_valid(sv), .i_sample_data(sd), .o_mem_wr(mwr), .o_mem_addr(maddr),
		.o_mem_data(mdata), .o_host_valid(hval), .o_host_word(hword),
		.i_host_ready(host_ready), .o_slow_valid(slow_v), .o_slow_data(slow_d),
		.o_stream_mode(strm), .o_dsp_select(dsp), .o_busy(busy), .o_done(done),
		.o_overrun(ovr));
	ams_host_model u_host (.i_core_clk(clk), .i_rst_b(rst_b), .i_host_valid(hval),
		.i_host_word(hword), .o_host_ready(host_ready));

	initial begin
		forever #50 clk = ~clk;
	end

	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		n_errors += rq.size() + mq.size() + hq.size() + sq.size();
		$display("errors=%0d checks=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// Every access is noted; the watcher compares the answer one cycle on
	task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d,
		input logic e, input logic [31:0] r);
		rq.push_back({3'b000, e, r});
		req = '{wr, !wr, a, d};
		@(negedge clk);
		req = '0;
		@(negedge clk);
	endtask

	task automatic run_one(input logic [31:0] m);
		int k, s, a;
		logic one, gm, full, ok;
		one = |(m & SINGLE_MODES);
		gm = |(m & GATED_MODES);
		full = 1'b0;
		a = 0;
		glvl = 1'($urandom);
		acc(1'b1, ADDR_MODE_SELECT, m, 1'b0, 32'h0000_0000);
		run = 1'b1;
		repeat (2) @(negedge clk);
		acc(1'b1, ADDR_MODE_SELECT, MODE_MEM_MULTI, 1'b1, 32'h0000_0000);
		// Gated runs: first burst with gate off, second one overfills memory
		for (s = 0; s < (one ? 1 : 2); s++) begin
			trig = 1'b1;
			gate = (s == 0) ? !glvl : glvl;
			repeat (5) @(negedge clk);
			for (k = 0; k < (gm ? 17 : 2); k++) begin
				sd = 16'($urandom);
				ok = (!gm || gate == glvl) && !full;
				if (ok) mq.push_back({16'h0000, 4'(a), sd});
				if (ok && (m & STREAM_MODES)) hq.push_back({19'h0_0000, 1'b0, sd});
				if (ok && (m & SLOW_MODES) && a % 2 == 1) begin
					if (m & STREAM_MODES) hq.push_back({19'h0_0000, 1'b1, sd});
					else sq.push_back({20'h0_0000, sd});
				end
				if (ok) a++;
				full = (a == 16) && !(m & STREAM_MODES);
				sv = 1'b1;
				@(negedge clk);
			end
			sv = 1'b0;
			trig = 1'b0;
			repeat (3) @(negedge clk);
		end
		check({35'h0, done}, {35'h0, one | full});
		check({35'h0, busy}, {35'h0, !(one | full)});
		check({35'h0, ovr}, 36'h0);
		run = 1'b0;
		repeat (3) @(negedge clk);
		check({35'h0, busy}, 36'h0);
		for (k = 0; k < 200 && hq.size() != 0; k++) @(negedge clk);
	endtask

	always @(negedge clk) begin
		if (ack === 1'b1) check({3'b000, err, rdata}, rq.size() ? rq.pop_front() : 'x);
		if (mwr === 1'b1) check({16'h0000, maddr, mdata}, mq.size() ? mq.pop_front() : 'x);
		if (slow_v === 1'b1) check({20'h0, slow_d}, sq.size() ? sq.pop_front() : 'x);
	end

	// No host word may leave in a memory-only mode
	always @(posedge clk) begin
		if (hval === 1'b1 && host_ready === 1'b1)
			check({19'h0, hword}, hq.size() ? hq.pop_front() : 'x);
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			close_out();
		end
	end

	initial begin
		void'($urandom(41382));
		caps = BASE_MODES | STATS_MODES | AVERAGE_MODES | BOXCAR_MODES;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		acc(1'b0, ADDR_MODE_SELECT, 32'h0, 1'b0, MODE_RESET);
		acc(1'b0, ADDR_SUPPORTED, 32'h0, 1'b0, caps);
		acc(1'b1, ADDR_SUPPORTED, 32'h0000_0002, 1'b1, 32'h0);
		acc(1'b0, 16'h2520, 32'h0, 1'b1, 32'h0);
		acc(1'b1, ADDR_MODE_SELECT, 32'h0, 1'b1, 32'h0);
		acc(1'b1, ADDR_MODE_SELECT, 32'h0000_0011, 1'b1, 32'h0);
		cur = MODE_RESET;
		for (int i = 0; i < 32; i++) begin
			acc(1'b1, ADDR_MODE_SELECT, 32'h1 << i, !caps[i], 32'h0);
			if (caps[i]) cur = 32'h1 << i;
			acc(1'b0, ADDR_MODE_SELECT, 32'h0, 1'b0, cur);
			check({35'h0, strm}, {35'h0, |(cur & STREAM_MODES)});
			check({34'h0, dsp}, {34'h0, (cur & STATS_MODES) ? DSP_STATS :
				(cur & AVERAGE_MODES) ? DSP_AVERAGE : (cur & BOXCAR_MODES) ? DSP_BOXCAR
				: DSP_NONE});
		end
		foreach (runs[j]) run_one(runs[j]);
		repeat (4) @(negedge clk);
		close_out();
	end
endmodule // ams_acq_mode_select_bench

/* ams_fifo.sv */
`timescale 1ns/1ps
module ams_fifo #(
	parameter int W     = 17,
	parameter int DEPTH = 32
) (
	input  wire logic         i_core_clk,   // Core clock
	input  wire logic         i_rst_b,      // Async reset, low
	input  wire logic         i_in_valid,   // Write request
	output logic              o_in_ready,   // Room left
	input  wire logic [W-1:0] i_in_data,    // Write word
	output logic              o_out_valid,  // Word available
	input  wire logic         i_out_ready,  // Read request
	output logic [W-1:0]      o_out_data    // Oldest word
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("ams_fifo depth must be a power of two");
	end

	logic [W-1:0]  store [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0]   count;
	logic [AW:0]   next_count;
	logic          push;
	logic          pop;

	assign o_in_ready  = (count != (AW + 1)'(DEPTH));
	assign o_out_valid = (count != '0);
	assign o_out_data  = store[rd_ptr];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_comb begin
		next_wr_ptr = push ? wr_ptr + 1'h1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'h1 : rd_ptr;
		next_count  = count + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// Storage needs no reset; count guards reads
	always_ff @(posedge i_core_clk) begin
		if (push) begin
			store[wr_ptr] <= i_in_data;
		end
	end
endmodule // ams_fifo

/* ams_host_model.sv */
`timescale 1ns/1ps
module ams_host_model (
	input  wire logic                i_core_clk,    // Core clock
	input  wire logic                i_rst_b,       // Async reset, low
	input  wire logic                i_host_valid,  // Word offered
	input  wire ams_pkg::ams_word_t  i_host_word,   // Word offered
	output logic                     o_host_ready   // Host accepts
);
	import ams_pkg::*;
	// Stalls one cycle in four so the FIFO holds words and must keep order
	always @(negedge i_core_clk) begin
		o_host_ready <= i_rst_b && (($urandom % 4) != 0);
	end
endmodule // ams_host_model

/* ams_mode_decode.sv */
`timescale 1ns/1ps
module ams_mode_decode #(
	parameter logic [7:0] P_FW_VERSION  = 8'h1d,
	parameter bit         P_HAS_STATS   = 1'b1,
	parameter bit         P_HAS_AVERAGE = 1'b1
) (
	input  wire logic [31:0]      i_mode,          // Mode in use
	input  wire logic [31:0]      i_wr_value,      // Value being written
	output logic [31:0]           o_caps,          // Supported bitmap
	output logic                  o_wr_one_hot,    // Exactly one bit set
	output logic                  o_wr_supported,  // Bit present in bitmap
	output logic                  o_stream,        // Streaming class
	output logic                  o_single,        // One trigger only
	output logic                  o_gated,         // Gate controlled
	output logic                  o_slow,          // Slow stream wanted
	output ams_pkg::ams_dsp_t     o_dsp            // Firmware module
);
	import ams_pkg::*;

	function automatic logic in_set(input logic [31:0] value, input logic [31:0] set);
		return (value & set) != 32'h0000_0000;
	endfunction

	always_comb begin
		o_caps = BASE_MODES;
		if (P_HAS_STATS) begin
			o_caps = o_caps | STATS_MODES;
		end
		if (P_HAS_AVERAGE) begin
			o_caps = o_caps | AVERAGE_MODES;
		end
		// Boxcar needs a recent enough firmware
		if (P_FW_VERSION >= BOXCAR_MIN_FW) begin
			o_caps = o_caps | BOXCAR_MODES;
		end
	end

	assign o_wr_one_hot   = ams_one_hot(i_wr_value);
	assign o_wr_supported = (i_wr_value & ~o_caps) == 32'h0000_0000;
	assign o_stream       = in_set(i_mode, STREAM_MODES);
	assign o_single       = in_set(i_mode, SINGLE_MODES);
	assign o_gated        = in_set(i_mode, GATED_MODES);
	assign o_slow         = in_set(i_mode, SLOW_MODES);

	always_comb begin
		if (in_set(i_mode, BOXCAR_MODES)) begin
			o_dsp = DSP_BOXCAR;
		end else if (in_set(i_mode, AVERAGE_MODES)) begin
			o_dsp = DSP_AVERAGE;
		end else if (in_set(i_mode, STATS_MODES)) begin
			o_dsp = DSP_STATS;
		end else begin
			o_dsp = DSP_NONE;
		end
	end
endmodule // ams_mode_decode

/* ams_pkg.sv */
package ams_pkg;

	localparam logic [15:0] ADDR_MODE_SELECT = 16'h251c;
	localparam logic [15:0] ADDR_SUPPORTED   = 16'h251d;

	localparam logic [31:0] MODE_MEM_SINGLE            = 32'h0000_0001;
	localparam logic [31:0] MODE_MEM_MULTI             = 32'h0000_0002;
	localparam logic [31:0] MODE_MEM_GATED             = 32'h0000_0004;
	localparam logic [31:0] MODE_MEM_DUAL_RATE         = 32'h0000_0008;
	localparam logic [31:0] MODE_STREAM_SINGLE         = 32'h0000_0010;
	localparam logic [31:0] MODE_STREAM_MULTI          = 32'h0000_0020;
	localparam logic [31:0] MODE_STREAM_GATED          = 32'h0000_0040;
	localparam logic [31:0] MODE_STREAM_DUAL_RATE      = 32'h0000_0080;
	localparam logic [31:0] MODE_MEM_SEG_STATISTICS    = 32'h0001_0000;
	localparam logic [31:0] MODE_MEM_BLOCK_AVERAGE     = 32'h0002_0000;
	localparam logic [31:0] MODE_STREAM_SEG_STATISTICS = 32'h0010_0000;
	localparam logic [31:0] MODE_STREAM_BLOCK_AVERAGE  = 32'h0020_0000;
	localparam logic [31:0] MODE_MEM_BOXCAR            = 32'h0080_0000;
	localparam logic [31:0] MODE_STREAM_BOXCAR         = 32'h0100_0000;
	localparam logic [31:0] MODE_STREAM_SINGLE_WITH_MONITOR = 32'h0200_0000;

	localparam logic [31:0] MODE_RESET = MODE_MEM_SINGLE;

	localparam logic [31:0] BASE_MODES = MODE_MEM_SINGLE | MODE_MEM_MULTI | MODE_MEM_GATED
		| MODE_MEM_DUAL_RATE | MODE_STREAM_SINGLE | MODE_STREAM_MULTI | MODE_STREAM_GATED
		| MODE_STREAM_DUAL_RATE | MODE_STREAM_SINGLE_WITH_MONITOR;
	localparam logic [31:0] STATS_MODES   = MODE_MEM_SEG_STATISTICS | MODE_STREAM_SEG_STATISTICS;
	localparam logic [31:0] AVERAGE_MODES = MODE_MEM_BLOCK_AVERAGE | MODE_STREAM_BLOCK_AVERAGE;
	localparam logic [31:0] BOXCAR_MODES  = MODE_MEM_BOXCAR | MODE_STREAM_BOXCAR;
	localparam logic [31:0] STREAM_MODES  = MODE_STREAM_SINGLE | MODE_STREAM_MULTI
		| MODE_STREAM_GATED | MODE_STREAM_DUAL_RATE | MODE_STREAM_SEG_STATISTICS
		| MODE_STREAM_BLOCK_AVERAGE | MODE_STREAM_BOXCAR | MODE_STREAM_SINGLE_WITH_MONITOR;
	localparam logic [31:0] SINGLE_MODES  = MODE_MEM_SINGLE | MODE_STREAM_SINGLE
		| MODE_STREAM_SINGLE_WITH_MONITOR;
	localparam logic [31:0] GATED_MODES   = MODE_MEM_GATED | MODE_STREAM_GATED;
	localparam logic [31:0] SLOW_MODES    = MODE_MEM_DUAL_RATE | MODE_STREAM_DUAL_RATE
		| MODE_STREAM_SINGLE_WITH_MONITOR;

	localparam logic [7:0]  BOXCAR_MIN_FW = 8'h1d;
	localparam int          SAMPLE_W      = 16;
	localparam int          FIFO_DEPTH    = 32;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} ams_reg_req_t;

	typedef struct packed {
		logic                slow;
		logic [SAMPLE_W-1:0] data;
	} ams_word_t;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ARMED   = 2'b01,
		ST_CAPTURE = 2'b10,
		ST_DONE    = 2'b11
	} ams_state_t;

	typedef enum logic [1:0] {
		DSP_NONE    = 2'b00,
		DSP_STATS   = 2'b01,
		DSP_AVERAGE = 2'b10,
		DSP_BOXCAR  = 2'b11
	} ams_dsp_t;

	function automatic logic ams_one_hot(input logic [31:0] value);
		return (value != 32'h0000_0000) && ((value & (value - 32'h0000_0001)) == 32'h0000_0000);
	endfunction

endpackage
